// *** flash_device_model.sv ***
`timescale 1ns/1ps
module flash_device_model #(
    parameter logic [31:0] LOCKS   = 32'h0000000f,
    parameter int          BUSY_NS = 300
) (
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  dq_in,
    output logic [7:0]       dq_out,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        power_down_reset_pin_n,
    input  wire logic [1:0]  fail_mode,
    input  wire logic        slow,
    output logic [15:0]      last_word,
    output logic [18:0]      last_addr,
    output logic [5:0]       erased_cnt
);
    // ------------------------------------------------------------
    // Command decoder and status
    // ------------------------------------------------------------
    logic [7:0] stat_r  = 8'h80;
    logic [7:0] cmd_r   = 8'h0;
    logic [7:0] lo_r    = 8'h0;
    logic [7:0] hi_r    = 8'h0;
    logic [1:0] phase_r = 2'h0;
    logic       sel_r   = 1'h0;
    logic       prot_r  = 1'h1;
    logic       array_r = 1'h1;
    logic       all_lock_r = 1'h1;
    int         i;

    initial last_word = 16'h0;
    initial last_addr = 19'h0;
    initial erased_cnt = 6'h0;

    // A released bus shows the inverse of the status, never a stale copy.
    assign dq_out = (!ce_n && !oe_n && power_down_reset_pin_n)
                    ? (array_r ? last_word[7:0] : stat_r) : ~stat_r;

    // The decoder does not sample new writes while busy.
    task automatic work();
        stat_r[7] = 1'h0;
        #(slow ? 4 * BUSY_NS : BUSY_NS);
        stat_r[7] = 1'h1;
    endtask

    always @(negedge power_down_reset_pin_n or posedge we_n) begin
        if (!power_down_reset_pin_n) begin
            prot_r = 1'h1;
            all_lock_r = 1'h1;
            phase_r = 2'h0;
            stat_r = 8'h80;
            array_r = 1'h1;
        end else if (!ce_n) begin
            case (phase_r)
                2'h0: begin
                    cmd_r = dq_in;
                    array_r = 1'h0;
                    case (dq_in)
                        8'hfb: phase_r = 2'h1;
                        8'ha7, 8'h47, 8'h57: phase_r = 2'h3;
                        8'h50: stat_r[5:3] = 3'h0;
                        8'hff: array_r = 1'h1;
                        default: stat_r[5:4] = 2'h3;
                    endcase
                end
                2'h1: begin
                    sel_r = addr[10];
                    if (sel_r) hi_r = dq_in;
                    else lo_r = dq_in;
                    phase_r = 2'h2;
                end
                2'h2: begin
                    phase_r = 2'h0;
                    if (sel_r) lo_r = dq_in;
                    else hi_r = dq_in;
                    last_addr = addr;
                    if (all_lock_r || (prot_r && LOCKS[addr[18:14]])) begin
                        stat_r[5:4] = 2'h3;
                    end else begin
                        work();
                        last_word = {hi_r, lo_r};
                    end
                end
                default: begin
                    phase_r = 2'h0;
                    if (dq_in != 8'hd0 || (cmd_r != 8'ha7 && addr != 19'h000ff)) begin
                        stat_r[5:4] = 2'h3;
                    end else if (cmd_r == 8'ha7) begin
                        work();
                        erased_cnt = 6'h0;
                        for (i = 0; i < 32; i++) begin
                            if (!(prot_r && LOCKS[i])) erased_cnt = erased_cnt + 6'h1;
                        end
                        stat_r[5] = fail_mode != 2'h0;
                        stat_r[3] = fail_mode == 2'h2;
                    end else begin
                        prot_r = cmd_r == 8'h57;
                        all_lock_r = 1'h0;
                    end
                end
            endcase
        end
    end
endmodule

// *** flash_host.sv ***
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module flash_host
    import flash_host_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq,
    output logic [18:0]      flash_addr,
    output logic [7:0]       flash_dq_o,
    output logic             flash_dq_oe,
    input  wire logic [7:0]  flash_dq_i,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             power_down_reset_pin_n
);

    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_SETUP  = 2'b01,
        S_STROBE = 2'b11,
        S_HOLD   = 2'b10
    } cyc_t;

    cyc_t        state_r;
    op_t         op_r;
    logic [1:0]  idx_r;
    logic        rd_r;
    logic [3:0]  cnt_r;
    logic [18:0] addr_r;
    logic [15:0] wdata_r;
    logic        pdown_r;
    logic [7:0]  fstat_r;
    logic        err_pend_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;
    logic [7:0]  dq_s1_r;
    logic [7:0]  dq_s2_r;
    logic        wr_ph_r;
    logic [7:0]  wr_off_r;
    logic        start;
    logic        refuse;
    logic        finish;
    logic        poll_ok;
    logic [12:0] step;
    logic [12:0] step_next;
    logic [2:0]  irq_set;

    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // Command step table: valid, address select, data select, byte.
    // ------------------------------------------------------------
    function automatic logic [12:0] step_of(input op_t op, input logic [1:0] i);
        logic [12:0] s;
        s = 13'h0000;
        unique case (op)
            OP_TWO_BYTE: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_TWO_BYTE};
                if (i == 2'd1) s = {1'b1, 2'd2, 2'd1, 8'h00};
                if (i == 2'd2) s = {1'b1, 2'd3, 2'd2, 8'h00};
            end
            OP_ERASE: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_ERASE};
                if (i == 2'd1) s = {1'b1, 2'd0, 2'd0, CMD_CONFIRM};
            end
            OP_UNPROT: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_UNPROT};
                if (i == 2'd1) s = {1'b1, 2'd1, 2'd0, CMD_CONFIRM};
            end
            OP_PROT: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_PROT};
                if (i == 2'd1) s = {1'b1, 2'd1, 2'd0, CMD_CONFIRM};
            end
            OP_CLEAR: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_CLEAR};
            end
            OP_ARRAY: begin
                if (i == 2'd0) s = {1'b1, 2'd0, 2'd0, CMD_ARRAY};
            end
            default: s = 13'h0000;
        endcase
        return s;
    endfunction

    assign step = step_of(op_r, idx_r);
    assign step_next = step_of(op_r, idx_r + 2'd1);

    // ------------------------------------------------------------
    // AHB-Lite slave.
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_r   <= 1'b0;
            wr_off_r  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
        end else begin
            wr_ph_r  <= hsel && hready && htrans[1] && hwrite;
            wr_off_r <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                unique case (haddr[7:0])
                    OFF_CTRL:     hrdata <= {23'h0, pdown_r, 5'h0, op_r};
                    OFF_ADDR:     hrdata <= {13'h0, addr_r};
                    OFF_WDATA:    hrdata <= {16'h0, wdata_r};
                    OFF_STATUS:   hrdata <= {22'h0, err_pend_r, state_r != S_IDLE, fstat_r};
                    OFF_IRQ_STAT: hrdata <= {29'h0, irq_stat_r};
                    OFF_IRQ_MASK: hrdata <= {29'h0, irq_mask_r};
                    default:      hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign start  = wr_ph_r && wr_off_r == OFF_CTRL && hwdata[CTRL_START];
    // Any command is refused while busy; a write, erase or protection command also while error bits wait to be cleared.
    assign refuse = start && (state_r != S_IDLE
                    || (err_pend_r && hwdata[2:0] <= 3'(OP_PROT)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r     <= 19'h00000;
            wdata_r    <= 16'h0000;
            pdown_r    <= 1'b0;
            irq_mask_r <= IRQ_RESET;
        end else if (wr_ph_r) begin
            if (wr_off_r == OFF_CTRL) pdown_r <= hwdata[CTRL_PDOWN];
            if (wr_off_r == OFF_ADDR) addr_r <= hwdata[18:0];
            if (wr_off_r == OFF_WDATA) wdata_r <= hwdata[15:0];
            if (wr_off_r == OFF_IRQ_MASK) irq_mask_r <= hwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Flash bus cycle engine.
    // ------------------------------------------------------------
    assign poll_ok = rd_r && state_r == S_HOLD && cnt_r == HOLD_CYC - 4'd1
                     && dq_s2_r[FS_READY];
    assign finish  = state_r == S_HOLD && cnt_r == HOLD_CYC - 4'd1
                     && (poll_ok || (!rd_r && !step_next[12]
                                     && op_r >= OP_CLEAR));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            op_r    <= OP_ARRAY;
            idx_r   <= 2'd0;
            rd_r    <= 1'b0;
            cnt_r   <= 4'd0;
        end else begin
            cnt_r <= cnt_r + 4'd1;
            unique case (state_r)
                S_IDLE: begin
                    cnt_r <= 4'd0;
                    if (start && !refuse) begin
                        op_r    <= op_t'(hwdata[2:0]);
                        idx_r   <= 2'd0;
                        rd_r    <= 1'b0;
                        state_r <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_r == SETUP_CYC - 4'd1) begin
                        cnt_r   <= 4'd0;
                        state_r <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (cnt_r == PULSE_CYC - 4'd1) begin
                        cnt_r   <= 4'd0;
                        state_r <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (cnt_r == HOLD_CYC - 4'd1) begin
                        cnt_r   <= 4'd0;
                        state_r <= S_SETUP;
                        if (finish) begin
                            state_r <= S_IDLE;
                        end else if (!rd_r) begin
                            if (step_next[12]) idx_r <= idx_r + 2'd1;
                            else rd_r <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_addr  <= 19'h00000;
            flash_dq_o  <= 8'h00;
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
        end else begin
            flash_ce_n  <= state_r == S_IDLE;
            flash_dq_oe <= state_r != S_IDLE && !rd_r;
            flash_we_n  <= !(state_r == S_SETUP && cnt_r == SETUP_CYC - 4'd1 && !rd_r)
                           && !(state_r == S_STROBE && cnt_r != PULSE_CYC - 4'd1 && !rd_r);
            flash_oe_n  <= !(state_r == S_SETUP && cnt_r == SETUP_CYC - 4'd1 && rd_r)
                           && !(state_r == S_STROBE && cnt_r != PULSE_CYC - 4'd1 && rd_r);
            unique case (step[11:10])
                2'd0: flash_addr <= 19'h00000;
                2'd1: flash_addr <= PROT_ADDR;
                2'd2: flash_addr <= 19'h00000;
                2'd3: flash_addr <= addr_r | (19'h00001 << BYTE_SEL_BIT);
            endcase
            unique case (step[9:8])
                2'd1:    flash_dq_o <= wdata_r[7:0];
                2'd2:    flash_dq_o <= wdata_r[15:8];
                default: flash_dq_o <= step[7:0];
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_down_reset_pin_n <= 1'b0;
        end else begin
            power_down_reset_pin_n <= !pdown_r;
        end
    end

    // ------------------------------------------------------------
    // Status capture and interrupts.
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
        end else begin
            dq_s1_r <= flash_dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fstat_r    <= FSTAT_RESET;
            err_pend_r <= 1'b0;
        end else if (poll_ok) begin
            fstat_r    <= dq_s2_r;
            // Erase failure, sequence error and low voltage all hold off retries.
            err_pend_r <= dq_s2_r[FS_ERASE] | dq_s2_r[FS_DATA] | dq_s2_r[FS_VOLT];
        end else if (finish && op_r == OP_CLEAR) begin
            err_pend_r <= 1'b0;
        end
    end

    assign irq_set = {refuse, poll_ok && (dq_s2_r[FS_ERASE] | dq_s2_r[FS_DATA]
                      | dq_s2_r[FS_VOLT]), finish};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            if (wr_ph_r && wr_off_r == OFF_IRQ_STAT) irq_stat_r <= (irq_stat_r & ~hwdata[2:0]) | irq_set;
            else irq_stat_r <= irq_stat_r | irq_set;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    two_byte_setup_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_we_n) && op_r == OP_TWO_BYTE && idx_r == 2'd0 |-> flash_dq_o == 8'hfb)
        else $error("two-byte setup byte wrong");
    byte_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_we_n) && op_r == OP_TWO_BYTE && idx_r == 2'd2 |-> flash_addr[10])
        else $error("second data write lacks byte select");
    erase_confirm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_we_n) && op_r == OP_ERASE && idx_r == 2'd1 |-> flash_dq_o == 8'hd0)
        else $error("erase confirm byte wrong");
    prot_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_we_n) && op_r inside {OP_UNPROT, OP_PROT} && idx_r == 2'd1
        |-> flash_addr == 19'h000ff && flash_dq_o == 8'hd0)
        else $error("protection confirm address wrong");
    we_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
        else $error("write pulse width wrong");
    busy_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start && state_r != S_IDLE |=> irq_stat_r[IRQ_REFUSED] && $stable(op_r))
        else $error("command accepted while busy");
    err_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start && err_pend_r && hwdata[2:0] == 3'h1 && state_r == S_IDLE |=> state_r == S_IDLE)
        else $error("erase started with error bits pending");
    ready_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        poll_ok |=> state_r == S_IDLE && irq_stat_r[IRQ_DONE] && fstat_r[7])
        else $error("ready poll did not complete");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 irq == $past(|(irq_stat_r & irq_mask_r)))
        else $error("interrupt level mismatch");

endmodule

// *** flash_host_bench.sv ***
`timescale 1ns/1ps
module flash_host_bench
    import flash_host_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [31:0] LOCK_SET = 32'h000000f0;
    logic        hclk = 1'h0;
    logic        hresetn = 1'h0;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, irq, dq_oe, ce_n, oe_n, we_n, pdown_n;
    logic [31:0] hrdata, a, d;
    logic [18:0] faddr, last_addr;
    logic [7:0]  dq_o, dev_dq, dq_bus;
    logic [15:0] last_word;
    logic [5:0]  erased_cnt;
    logic [1:0]  fail_mode = 2'h0;
    logic        slow = 1'h0;
    logic [2:0]  mask_v = 3'h0;
    logic [63:0] q[$];
    logic [31:0] q_seen[$];
    int          n_seen = 0;
    int          n_done = 0;
    int          n_mismatch = 0;
    int          n_checks = 0;
    integer      seed = 42737;

    assign dq_bus = dq_oe ? dq_o : dev_dq;

    flash_host i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .irq(irq), .flash_addr(faddr), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .power_down_reset_pin_n(pdown_n));
    flash_device_model #(.LOCKS(LOCK_SET)) i_dev (.addr(faddr), .dq_in(dq_bus), .dq_out(dev_dq),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .power_down_reset_pin_n(pdown_n),
        .fail_mode(fail_mode), .slow(slow),
        .last_word(last_word), .last_addr(last_addr), .erased_cnt(erased_cnt));

    initial forever #5 hclk = ~hclk;

    // ------------------------------------------------------------
    // Bus tasks and result checking
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wval, output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wval;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        r = hrdata;
    endtask

    task automatic note(input logic [31:0] s, input logic [31:0] e, input logic [31:0] m);
        q.push_back({m, e});
        q_seen.push_back(s);
        n_seen++;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wval);
        logic [31:0] r;
        bus(1'h1, ad, wval, r);
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        bus(1'h0, ad, 32'h0, r);
        note(r, e, m);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic start(input op_t op);
        wr(OFF_CTRL, 32'h8 | 32'(op));
    endtask

    task automatic finish(input logic [2:0] e);
        logic [31:0] r;
        int          n;
        n = 0;
        do begin
            bus(1'h0, OFF_IRQ_STAT, 32'h0, r);
            n++;
        end while (r[IRQ_DONE] !== 1'h1 && n < 2000);
        note(r, {29'h0, e}, 32'h7);
        @(posedge hclk);
        note({31'h0, irq}, {31'h0, |(e & mask_v)}, 32'h1);
        wr(OFF_IRQ_STAT, 32'h7);
        repeat (2) @(posedge hclk);
        note({31'h0, irq}, 32'h0, 32'h1);
    endtask

    task automatic run(input op_t op, input logic [2:0] e);
        start(op);
        finish(e);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial forever begin
        logic [63:0] e;
        wait (n_seen > n_done);
        e = q.pop_front();
        check(q_seen.pop_front() & e[63:32], e[31:0] & e[63:32]);
        n_done++;
    end

    initial begin
        #900000;
        n_mismatch++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rdc(OFF_STATUS, 32'h0, 32'h3ff);
        rdc(OFF_IRQ_STAT, 32'h0, 32'h7);
        note({31'h0, hresp}, 32'h0, 32'h1);
        wr(8'h18, 32'($random(seed)));
        rdc(8'h18, 32'h0, 32'hffffffff);
        $display("test reset done");
        wr(OFF_ADDR, 32'h123);
        wr(OFF_WDATA, 32'h5aa5);
        run(OP_TWO_BYTE, 3'h3);
        rdc(OFF_STATUS, 32'h2b0, 32'h3ff);
        start(OP_ERASE);
        rdc(OFF_IRQ_STAT, 32'h4, 32'h7);
        wr(OFF_IRQ_STAT, 32'h7);
        run(OP_CLEAR, 3'h1);
        rdc(OFF_STATUS, 32'h0, 32'h300);
        run(OP_UNPROT, 3'h1);
        rdc(OFF_STATUS, 32'h80, 32'h3ff);
        $display("test protection done");
        for (int k = 0; k < 3; k++) begin
            a = 32'($random(seed)) & 32'h7ffff | 32'h40000;
            d = 32'($random(seed));
            slow <= d[16];
            wr(OFF_ADDR, a);
            wr(OFF_WDATA, d);
            run(OP_TWO_BYTE, 3'h1);
            note({16'h0, last_word}, d, 32'hffff);
            note({13'h0, last_addr}, a | 32'h400, 32'h7ffff);
        end
        $display("test two byte done");
        run(OP_PROT, 3'h1);
        run(OP_ERASE, 3'h1);
        note({26'h0, erased_cnt}, 32 - $countones(LOCK_SET), 32'h3f);
        run(OP_UNPROT, 3'h1);
        run(OP_ERASE, 3'h1);
        note({26'h0, erased_cnt}, 32'h20, 32'h3f);
        $display("test erase done");
        mask_v = 3'h7;
        wr(OFF_IRQ_MASK, 32'h7);
        rdc(OFF_IRQ_MASK, 32'h7, 32'h7);
        for (int k = 1; k < 3; k++) begin
            fail_mode <= 2'(k);
            run(OP_ERASE, 3'h3);
            rdc(OFF_STATUS, k == 2 ? 32'h2a8 : 32'h2a0, 32'h3ff);
            fail_mode <= 2'h0;
            run(OP_CLEAR, 3'h1);
            run(OP_ERASE, 3'h1);
            rdc(OFF_STATUS, 32'h80, 32'h3ff);
        end
        $display("test failure done");
        slow <= 1'h1;
        start(OP_ERASE);
        rdc(OFF_STATUS, 32'h100, 32'h100);
        start(OP_ERASE);
        finish(3'h5);
        slow <= 1'h0;
        run(OP_ARRAY, 3'h1);
        wr(OFF_CTRL, 32'h100);
        repeat (3) @(posedge hclk);
        note({31'h0, pdown_n}, 32'h0, 32'h1);
        wr(OFF_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        note({31'h0, pdown_n}, 32'h1, 32'h1);
        $display("test busy and power down done");
        print_verdict();
    end
endmodule

// *** flash_host_pkg.sv ***
package flash_host_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_ADDR     = 8'h04;
    localparam logic [7:0]  OFF_WDATA    = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h14;
    localparam int          CTRL_START   = 3;
    localparam int          CTRL_PDOWN   = 8;
    localparam int          STAT_BUSY    = 8;
    localparam int          STAT_ERRPEND = 9;
    localparam int          IRQ_DONE     = 0;
    localparam int          IRQ_ERROR    = 1;
    localparam int          IRQ_REFUSED  = 2;
    localparam logic [2:0]  IRQ_RESET    = 3'h0;
    localparam logic [7:0]  FSTAT_RESET  = 8'h00;

    // ------------------------------------------------------------
    // Flash commands and status bits
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_TWO_BYTE = 8'hfb;
    localparam logic [7:0]  CMD_ERASE    = 8'ha7;
    localparam logic [7:0]  CMD_CONFIRM  = 8'hd0;
    localparam logic [7:0]  CMD_UNPROT   = 8'h47;
    localparam logic [7:0]  CMD_PROT     = 8'h57;
    localparam logic [7:0]  CMD_CLEAR    = 8'h50;
    localparam logic [7:0]  CMD_ARRAY    = 8'hff;
    localparam logic [18:0] PROT_ADDR    = 19'h000ff;
    localparam int          BYTE_SEL_BIT = 10;
    localparam int          FS_READY     = 7;
    localparam int          FS_ERASE     = 5;
    localparam int          FS_DATA      = 4;
    localparam int          FS_VOLT      = 3;

    typedef enum logic [2:0] {
        OP_TWO_BYTE = 3'h0,
        OP_ERASE    = 3'h1,
        OP_UNPROT   = 3'h2,
        OP_PROT     = 3'h3,
        OP_CLEAR    = 3'h4,
        OP_ARRAY    = 3'h5
    } op_t;

    // ------------------------------------------------------------
    // Bus cycle timing
    // ------------------------------------------------------------
    localparam int          CLK_NS       = 10;
    localparam int          T_SETUP_NS   = 20;
    localparam int          T_PULSE_NS   = 50;
    localparam int          T_HOLD_NS    = 20;
    localparam logic [3:0]  SETUP_CYC    = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  PULSE_CYC    = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  HOLD_CYC     = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

endpackage
